// ---- include/flash_ctl_pkg.sv ----
// Package of constants shared by the flash controller and the core-side end
`default_nettype none
package flash_ctl_pkg;
	localparam int          ADDR_W          = 14;
	localparam int          PAGE_W          = 9;           // 512-byte page
	localparam int          FLASH_BYTES     = 16384;
	localparam logic [7:0]  KEY_FIRST       = 8'ha5;
	localparam logic [7:0]  KEY_SECOND      = 8'hf1;
	localparam logic [7:0]  ERASED_BYTE     = 8'hff;
	localparam int          CLK_MHZ         = 100;
	// Cycle times in their own units, typical figures
	localparam int          WRITE_TIME_US   = 55;
	localparam int          ERASE_TIME_MS   = 15;
	localparam int          WRITE_CYCLES    = WRITE_TIME_US * CLK_MHZ;
	localparam int          ERASE_CYCLES    = ERASE_TIME_MS * 1000 * CLK_MHZ;
	localparam int          CNT_W           = 24;
	// Control register bit positions
	localparam int          CTL_WE_BIT      = 0;
	localparam int          CTL_EE_BIT      = 1;
	localparam logic [1:0]  CTL_RESET       = 2'h0;
	typedef enum logic [1:0] {KEY_LOCKED, KEY_FIRST_SEEN, KEY_ARMED, KEY_DISABLED} key_state_t;
endpackage
`default_nettype wire

// ---- include/flash_core_if.sv ----
// Interface joining the core-side end and the flash controller
`default_nettype none
interface flash_core_if;
	logic                               ctl_wr;
	logic [1:0]                         ctl_wdata;
	logic [1:0]                         ctl_rdata;
	logic                               key_wr;
	logic [7:0]                         key_wdata;
	logic                               store;
	logic [flash_ctl_pkg::ADDR_W-1:0]   store_addr;
	logic [7:0]                         store_data;
	logic                               code_rd;
	logic [flash_ctl_pkg::ADDR_W-1:0]   code_addr;
	logic [7:0]                         code_data;
	logic                               external_data_ram_we;
	logic                               stall;
	logic                               flash_error;
	modport ctl (input ctl_wr, ctl_wdata, key_wr, key_wdata, store, store_addr, store_data,
		code_rd, code_addr, output ctl_rdata, code_data, external_data_ram_we, stall, flash_error);
	modport core (output ctl_wr, ctl_wdata, key_wr, key_wdata, store, store_addr, store_data,
		code_rd, code_addr, input ctl_rdata, code_data, external_data_ram_we, stall, flash_error);
endinterface
`default_nettype wire

// ---- hdl/flash_program_erase_control.sv ----
// Flash program/erase controller: key lock, store redirection, timed stall, array
// Functional notes
// RL1: Program one byte per store, software or debug
// RL2: Programming only clears bits to zero
// RL3: Erase sets whole 512-byte page to 0xff
// RL4: Hardware times every write and erase
// RL5: Stall execution while operation runs
// RL6: Arm only after 0xa5 then 0xf1
// RL7: Any gap between key writes allowed
// RL8: Wrong or misordered key disables until reset
// RL9: Store before arming disables until reset
// RL10: Lock again after each completed operation
// RL11: Write-enable redirects stores to flash
// RL12: Write-enable holds until software clears it
// RL13: Erase needs both enables, keys, store
// RL14: Program needs write-enable, keys, one store
// RL15: Data reads go to RAM; code reads flash
// RL16: Software disables interrupts, clears write-enable
// RL17: Blank device programmable only via debug
// RL18: Erase needs both enables; program only write-enable
// RL19: Prohibited access sets flash error flag
// RL20: Stall length from parameter clock counts
// RL21: Key tracker locked, first, armed, disabled
`default_nettype none
module flash_program_erase_control #(
	parameter int WRITE_CYCLES = flash_ctl_pkg::WRITE_CYCLES,
	parameter int ERASE_CYCLES = flash_ctl_pkg::ERASE_CYCLES
) (
	// Clock and reset
	input  wire logic                             core_clk_i,
	input  wire logic                             resetn_i,
	// Core side
	flash_core_if.ctl                             bus,
	// Debug port programming path
	input  wire logic                             dbg_write_i,
	input  wire logic                             dbg_erase_i,
	input  wire logic [flash_ctl_pkg::ADDR_W-1:0] dbg_addr_i,
	input  wire logic [7:0]                       dbg_data_i,
	output logic                                  dbg_busy_o
);
	// Sequencer states
	typedef enum {IDLE, WRITING, ERASING} op_state_t;

	// Array, enables, key tracker and sequencer state
	logic [7:0]                       mem_q [flash_ctl_pkg::FLASH_BYTES];
	logic [1:0]                       ctl_q;
	flash_ctl_pkg::key_state_t        key_q;
	op_state_t                        op_q;
	logic [flash_ctl_pkg::CNT_W-1:0]  cnt_q;
	logic [flash_ctl_pkg::ADDR_W-1:0] addr_q;
	logic [7:0]                       data_q;
	logic [7:0]                       code_q;
	logic                             err_q;
	logic                             sw_store;
	logic                             sw_go;
	logic                             sw_erase;
	logic                             dbg_go;
	logic                             op_done;

	// Page base of an address
	function automatic logic [flash_ctl_pkg::ADDR_W-1:0] page_of(
		input logic [flash_ctl_pkg::ADDR_W-1:0] a);
		page_of = {a[flash_ctl_pkg::ADDR_W-1:flash_ctl_pkg::PAGE_W],
			{flash_ctl_pkg::PAGE_W{1'b0}}};
	endfunction

	// Timer load for an operation; the cycle at count zero is the finishing one
	function automatic logic [flash_ctl_pkg::CNT_W-1:0] cycles_for(input logic erase);
		if (erase) begin
			cycles_for = flash_ctl_pkg::CNT_W'(ERASE_CYCLES - 1);
		end else begin
			cycles_for = flash_ctl_pkg::CNT_W'(WRITE_CYCLES - 1);
		end
	endfunction

	// Stores go to flash only with write-enable; debug is the other path
	assign sw_store = bus.store && ctl_q[flash_ctl_pkg::CTL_WE_BIT] && (op_q == IDLE); // RL11
	assign sw_go    = sw_store && (key_q == flash_ctl_pkg::KEY_ARMED); // RL6
	assign sw_erase = ctl_q[flash_ctl_pkg::CTL_EE_BIT]; // RL18
	// Debug requests bypass key and enables, but yield to a software store
	assign dbg_go   = (dbg_write_i || dbg_erase_i) && (op_q == IDLE) && !sw_store; // RL17
	assign op_done  = (op_q != IDLE) && (cnt_q == '0);

	// Data stores reach RAM unless redirected; data reads always go to RAM
	assign bus.external_data_ram_we    = bus.store && !ctl_q[flash_ctl_pkg::CTL_WE_BIT]; // RL15
	assign bus.stall      = (op_q != IDLE); // RL5
	assign dbg_busy_o     = (op_q != IDLE);
	assign bus.ctl_rdata  = ctl_q;
	assign bus.code_data  = code_q;
	assign bus.flash_error = err_q;

	// Enable bits stay as written by software
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctl_q <= flash_ctl_pkg::CTL_RESET;
		end else if (bus.ctl_wr) begin
			ctl_q <= bus.ctl_wdata; // RL12
		end
	end

	// Key tracker; disabled state is left only through reset
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			key_q <= flash_ctl_pkg::KEY_LOCKED;
		end else begin
			case (key_q) // RL21
				flash_ctl_pkg::KEY_LOCKED: begin
					if (sw_store) begin
						key_q <= flash_ctl_pkg::KEY_DISABLED; // RL9
					end else if (bus.key_wr) begin
						key_q <= (bus.key_wdata == flash_ctl_pkg::KEY_FIRST) ?
							flash_ctl_pkg::KEY_FIRST_SEEN : flash_ctl_pkg::KEY_DISABLED; // RL8
					end
				end
				flash_ctl_pkg::KEY_FIRST_SEEN: begin
					// No timeout: the gap between codes is unbounded
					if (sw_store) begin
						key_q <= flash_ctl_pkg::KEY_DISABLED; // RL9
					end else if (bus.key_wr) begin
						key_q <= (bus.key_wdata == flash_ctl_pkg::KEY_SECOND) ?
							flash_ctl_pkg::KEY_ARMED : flash_ctl_pkg::KEY_DISABLED; // RL7
					end
				end
				flash_ctl_pkg::KEY_ARMED: begin
					// A further key write while armed counts as out of order
					if (sw_store) begin
						key_q <= flash_ctl_pkg::KEY_LOCKED; // RL10
					end else if (bus.key_wr) begin
						key_q <= flash_ctl_pkg::KEY_DISABLED; // RL8
					end
				end
				default: key_q <= flash_ctl_pkg::KEY_DISABLED;
			endcase
		end
	end

	// Sticky error flag, cleared only by reset
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			err_q <= 1'b0;
		end else if (sw_store && (key_q != flash_ctl_pkg::KEY_ARMED)) begin
			err_q <= 1'b1; // RL19
		end
	end

	// Operation state; software wins over the debug port in the same cycle
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			op_q <= IDLE;
		end else if (op_q == IDLE) begin
			if (sw_go) begin
				op_q <= sw_erase ? ERASING : WRITING; // RL13 RL14
			end else if (dbg_go) begin
				op_q <= dbg_erase_i ? ERASING : WRITING; // RL1
			end
		end else if (op_done) begin
			op_q <= IDLE; // RL4
		end
	end

	// Hardware cycle timer; counts down while the core is stalled
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_q <= '0;
		end else if (sw_go) begin
			cnt_q <= cycles_for(sw_erase); // RL20
		end else if (dbg_go) begin
			cnt_q <= cycles_for(dbg_erase_i); // RL20
		end else if ((op_q != IDLE) && !op_done) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	// Target address and data held for the whole timed cycle
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			addr_q <= '0;
			data_q <= 8'h00;
		end else if (sw_go) begin
			addr_q <= bus.store_addr;
			data_q <= bus.store_data;
		end else if (dbg_go) begin
			addr_q <= dbg_addr_i;
			data_q <= dbg_data_i;
		end
	end

	// Array update at the end of the timed cycle; no reset on storage,
	// so contents stay unknown until the first erase of a page
	always_ff @(posedge core_clk_i) begin
		if (op_done && (op_q == WRITING)) begin
			mem_q[addr_q] <= mem_q[addr_q] & data_q; // RL2
		end else if (op_done && (op_q == ERASING)) begin
			for (int i = 0; i < (1 << flash_ctl_pkg::PAGE_W); i++) begin
				mem_q[page_of(addr_q) | flash_ctl_pkg::ADDR_W'(i)] <=
					flash_ctl_pkg::ERASED_BYTE; // RL3
			end
		end
	end

	// Code-space read path returns stored flash data
	// Data-space reads never come here; they always go to RAM
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			code_q <= 8'h00;
		end else if (bus.code_rd) begin
			code_q <= mem_q[bus.code_addr]; // RL15
		end
	end
endmodule
`default_nettype wire

// ---- hdl/flash_core_port.sv ----
// Core-side end: turns user requests into key, control, store and code-read strobes
`default_nettype none
module flash_core_port (
	// Clock and reset
	input  wire logic                             core_clk_i,
	input  wire logic                             resetn_i,
	// Link to the controller
	flash_core_if.core                            bus,
	// User requests (one-cycle pulses, ignored while stalled)
	input  wire logic                             ctl_wr_i,
	input  wire logic [1:0]                       ctl_wdata_i,
	input  wire logic                             key_wr_i,
	input  wire logic [7:0]                       key_wdata_i,
	input  wire logic                             store_i,
	input  wire logic [flash_ctl_pkg::ADDR_W-1:0] addr_i,
	input  wire logic [7:0]                       data_i,
	input  wire logic                             code_rd_i,
	// User results
	output logic [1:0]                            ctl_rdata_o,
	output logic [7:0]                            code_data_o,
	output logic                                  external_data_ram_we_o,
	output logic                                  stall_o,
	output logic                                  flash_error_o
);
	logic go;

	// Core executes nothing while the controller stalls it
	assign go = !bus.stall;
	assign bus.ctl_wr     = ctl_wr_i && go;
	assign bus.ctl_wdata  = ctl_wdata_i;
	assign bus.key_wr     = key_wr_i && go; // RL6
	assign bus.key_wdata  = key_wdata_i;
	assign bus.store      = store_i && go; // RL14
	assign bus.store_addr = addr_i;
	assign bus.store_data = data_i;
	assign bus.code_rd    = code_rd_i && go;
	assign bus.code_addr  = addr_i;

	// Results back to the user
	assign ctl_rdata_o   = bus.ctl_rdata;
	assign code_data_o   = bus.code_data;
	assign external_data_ram_we_o     = bus.external_data_ram_we;
	assign stall_o       = bus.stall;
	assign flash_error_o = bus.flash_error;

	// Reset is only a port-list formality here; the end holds no state
	logic unused_rst;
	assign unused_rst = resetn_i & core_clk_i;
endmodule
`default_nettype wire

// ---- test/flash_link_assertions.sv ----
// Concurrent checks on the link between the core-side end and the flash controller
`default_nettype none
module flash_link_checker #(
	parameter int ERASE_CYCLES = 20
) (
	// Clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       resetn_i,
	// Link signals
	input  wire logic       ctl_wr,
	input  wire logic [1:0] ctl_wdata,
	input  wire logic [1:0] ctl_rdata,
	input  wire logic       key_wr,
	input  wire logic [7:0] key_wdata,
	input  wire logic       store,
	input  wire logic       external_data_ram_we,
	input  wire logic       stall,
	input  wire logic       flash_error
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int STALL_MAX = ERASE_CYCLES + 1;
	logic [7:0] key_q;
	logic       bad_q;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	// Last key byte since the last flash store; a store starts the sequence over
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			key_q <= 8'h00;
		else if (store && ctl_rdata[0])
			key_q <= 8'h00;
		else if (key_wr)
			key_q <= key_wdata;
	end
	// Sticky: any misordered key or unarmed store locks flash until reset
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i)
			bad_q <= 1'b0;
		else if (key_wr && !((key_q == 8'h00 && key_wdata == flash_ctl_pkg::KEY_FIRST) ||
				(key_q == flash_ctl_pkg::KEY_FIRST && key_wdata == flash_ctl_pkg::KEY_SECOND)))
			bad_q <= 1'b1;
		else if (store && ctl_rdata[0] && key_q != flash_ctl_pkg::KEY_SECOND)
			bad_q <= 1'b1;
	end
	stall_min_a: assert property ($rose(stall) |-> stall[*8])
		else $error("stall too short");
	stall_max_a: assert property ($rose(stall) |-> ##[1:STALL_MAX] !stall)
		else $error("stall too long");
	error_sticky_a: assert property (flash_error |=> flash_error)
		else $error("error flag dropped");
	armed_stall_a: assert property (store && ctl_rdata[0] && !bad_q &&
		key_q == flash_ctl_pkg::KEY_SECOND |=> stall) else $error("armed store did not stall");
	unarmed_error_a: assert property (store && ctl_rdata[0] &&
		key_q != flash_ctl_pkg::KEY_SECOND |=> flash_error && !stall) else $error("unarmed store");
	locked_store_a: assert property (bad_q && store |=> !stall)
		else $error("locked store ran");
	ram_route_a: assert property (store |-> external_data_ram_we == !ctl_rdata[0])
		else $error("store routed wrongly");
	enable_hold_a: assert property (!ctl_wr |=> $stable(ctl_rdata))
		else $error("enables changed");
	enable_load_a: assert property (ctl_wr |=> ctl_rdata == $past(ctl_wdata))
		else $error("enables not loaded");
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench joining the core-side end and the flash controller
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        core_clk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        ctl_wr = 1'b0, key_wr = 1'b0, store = 1'b0, code_rd = 1'b0;
	logic [13:0] addr = 14'h0000, a, pg;
	logic [7:0]  data = 8'h00, d1, d2;
	logic [1:0]  ctl_rdata_o;
	logic [7:0]  code_data_o;
	logic        external_data_ram_we_o, stall_o, flash_error_o, rd_seen;
	logic        dbg_write = 1'b0, dbg_erase = 1'b0, dbg_busy_o, ram_exp = 1'b1;
	logic [13:0] dbg_addr = 14'h0000;
	logic [7:0]  dbg_data = 8'h00;
	logic [7:0]  exp_q[$];
	int          bad_count = 0, samples_checked = 0;
	flash_core_if bus ();
	always #5 core_clk_i = ~core_clk_i;
	// Short cycle counts keep the run brief
	flash_program_erase_control #(.WRITE_CYCLES(8), .ERASE_CYCLES(20))
		flash_program_erase_control_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.bus(bus), .dbg_write_i(dbg_write), .dbg_erase_i(dbg_erase), .dbg_addr_i(dbg_addr),
		.dbg_data_i(dbg_data), .dbg_busy_o(dbg_busy_o));
	flash_core_port flash_core_port_inst (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
		.bus(bus), .ctl_wr_i(ctl_wr), .ctl_wdata_i(data[1:0]), .key_wr_i(key_wr),
		.key_wdata_i(data), .store_i(store), .addr_i(addr), .data_i(data),
		.code_rd_i(code_rd), .ctl_rdata_o(ctl_rdata_o), .code_data_o(code_data_o),
		.external_data_ram_we_o(external_data_ram_we_o), .stall_o(stall_o), .flash_error_o(flash_error_o));
	flash_link_checker #(.ERASE_CYCLES(20)) flash_link_checker_inst (.core_clk_i(core_clk_i),
		.resetn_i(resetn_i), .ctl_wr(bus.ctl_wr), .ctl_wdata(bus.ctl_wdata),
		.ctl_rdata(bus.ctl_rdata), .key_wr(bus.key_wr), .key_wdata(bus.key_wdata),
		.store(bus.store), .external_data_ram_we(bus.external_data_ram_we), .stall(bus.stall),
		.flash_error(bus.flash_error));
	task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// One-cycle pulse, flags in order ctl, key, store, code read
	task automatic req(input logic [3:0] f, input logic [13:0] ad, input logic [7:0] dt);
		@(negedge core_clk_i);
		{ctl_wr, key_wr, store, code_rd} = f;
		addr = ad;
		data = dt;
		@(negedge core_clk_i);
		{ctl_wr, key_wr, store, code_rd} = 4'h0;
		repeat (2) @(negedge core_clk_i);
	endtask
	// Key pair with a random gap between codes, then a store; waits out the stall
	task automatic prog(input logic [13:0] ad, input logic [7:0] dt);
		req(4'h4, 14'h0000, flash_ctl_pkg::KEY_FIRST);
		repeat ($urandom_range(6)) @(negedge core_clk_i);
		req(4'h4, 14'h0000, flash_ctl_pkg::KEY_SECOND);
		req(4'h2, ad, dt);
		wait_idle();
	endtask
	// Waits out a stall; one still standing after 100 cycles counts as a mismatch
	task automatic wait_idle();
		int n;
		n = 0;
		while (stall_o !== 1'b0 && n < 100) begin
			@(negedge core_clk_i);
			n++;
		end
		if (n >= 100)
			bad_count++;
	endtask
	// Enable write; the bench notes where later stores should land
	task automatic set_ctl(input logic [1:0] v);
		ram_exp = !v[0];
		req(4'h8, 14'h0000, {6'h00, v});
	endtask
	// One-cycle debug request, erase or write, then waits out the stall
	task automatic dbg(input logic er, input logic [13:0] ad, input logic [7:0] dt);
		@(negedge core_clk_i);
		{dbg_erase, dbg_write} = {er, !er};
		dbg_addr = ad;
		dbg_data = dt;
		@(negedge core_clk_i);
		{dbg_erase, dbg_write} = 2'b00;
		chk("dbg_busy", {7'h00, dbg_busy_o}, 8'h01);
		chk("stall", {7'h00, stall_o}, 8'h01);
		wait_idle();
	endtask
	task automatic rd(input logic [13:0] ad, input logic [7:0] e);
		exp_q.push_back(e);
		req(4'h1, ad, 8'h00);
	endtask
	task automatic rst();
		@(negedge core_clk_i);
		resetn_i = 1'b0;
		repeat (10) @(negedge core_clk_i);
		resetn_i = 1'b1;
		ram_exp = 1'b1;
	endtask
	// Watcher: read data stands one cycle after the read reaches the controller
	always @(posedge core_clk_i) rd_seen <= bus.code_rd;
	always @(negedge core_clk_i) begin
		if (rd_seen === 1'b1 && exp_q.size() > 0)
			chk("code_data", code_data_o, exp_q.pop_front());
	end
	// Store routing, looked at while the store still stands
	always @(posedge core_clk_i) begin
		if (bus.store === 1'b1) begin
			#1;
			chk("external_data_ram_we", {7'h00, external_data_ram_we_o}, {7'h00, ram_exp});
		end
	end
	initial begin
		void'($urandom(66440));
		rst();
		chk("enables", {6'h00, ctl_rdata_o}, 8'h00);
		pg = 14'($urandom_range(30)) << 9;
		req(4'h2, pg, 8'h3c);
		set_ctl(2'h3);
		chk("enables", {6'h00, ctl_rdata_o}, 8'h03);
		prog(pg | 14'($urandom_range(511)), 8'h00);
		rd(pg, flash_ctl_pkg::ERASED_BYTE);
		rd(pg | 14'h01ff, flash_ctl_pkg::ERASED_BYTE);
		set_ctl(2'h1);
		a = pg | 14'($urandom_range(511));
		d1 = 8'($urandom);
		d2 = 8'($urandom);
		prog(a, d1);
		rd(a, d1);
		prog(a, d2);
		rd(a, d1 & d2);
		// No fresh keys after a completed write, so this store must be refused
		req(4'h2, a, 8'h00);
		chk("error", {7'h00, flash_error_o}, 8'h01);
		rd(a, d1 & d2);
		set_ctl(2'h0);
		req(4'h2, a, 8'h00);
		rst();
		chk("error", {7'h00, flash_error_o}, 8'h00);
		set_ctl(2'h1);
		req(4'h4, 14'h0000, flash_ctl_pkg::KEY_FIRST);
		req(4'h4, 14'h0000, 8'h5a);
		prog(a, 8'h00);
		chk("error", {7'h00, flash_error_o}, 8'h01);
		rd(a, d1 & d2);
		// Debug port still works with the lock disabled and write-enable still set
		dbg(1'b1, a, 8'h00);
		rd(a, flash_ctl_pkg::ERASED_BYTE);
		dbg(1'b0, a, d1);
		rd(a, d1);
		chk("pending", 8'(exp_q.size()), 8'h00);
		end_sim();
	end
	initial begin
		#20us;
		bad_count++;
		end_sim();
	end
endmodule
`default_nettype wire
